// [frs_core.sv]
// Reset commands, reset pins and security row erase/program engine
// Function
// R1: Arm opcode frame then execute opcode frame resets
// R2: Any other command after arm disarms
// R3: Soft reset: normal mode, reload volatile copies
// R4: Shared pin resets only single-line, quad off
// R5: Enabled dedicated pin resets in every mode
// R6: Reset pin low at least 100 ns
// R7: Pin reset aborts, wakes, tristates, restores parameters
// R8: No instruction accepted 35 us after pin reset
// R9: Any reset aborts a running program or erase
// R10: Status and function contents survive reset
// R11: Four rows at middle byte 00/10/20/30
// R12: Row commands rejected while anything is busy
// R13: Lock bit set makes that row read-only
// R14: Row erase needs write latch set first
// R15: Erase starts on chip select rising edge
// R16: Write latch clears when erase completes
// R17: Row program needs write latch, up to 256
// R18: Program starts at frame end, else discarded
// R19: Busy ignores all but status; progress flag (the code still takes the reset arm and execute commands while busy)
// R20: Byte address wraps in page, last 256 kept
// R21: Bytes without data keep old contents
// R22: Programming only clears bits; erase sets them
`timescale 1ns/1ps
module frs_core
   import frs_pkg::*;
#(
   parameter int PROG_CYCLES = frs_pkg::PROG_CYC_DEFAULT,
   parameter int ERASE_CYCLES = frs_pkg::ERASE_CYC_DEFAULT
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link pins, asynchronous to core_clk
   input wire frs_pkg::frs_pins_type link_in,
   output logic [3:0] io_out_q,
   output logic [3:0] io_oe_q,
   // Configuration from status and function registers, plus external busy and mode entry strobes
   input wire logic quad_enable_bit,
   input wire logic hold_reset_select_bit,
   input wire logic dedicated_reset_disable,
   input wire logic [3:0] security_row_lock_bit,
   input wire logic [7:0] nv_read_params,
   input wire logic ext_busy,
   input wire logic quad_mode_enter,
   input wire logic dpd_enter,
   // State
   output logic write_enable_latch_q,
   output logic write_in_progress_flag,
   output logic quad_command_mode_q,
   output logic deep_power_down_q,
   output logic [7:0] read_params_q,
   output logic sw_reset_pulse_q,
   output logic hw_reset_active,
   output logic rx_fifo_ready,
   output logic rx_overrun_q,
   // Security row read port
   input wire logic [9:0] rd_index,
   output logic [7:0] rd_data_q
);
   localparam logic [15:0] PROG_END = 16'(PROG_CYCLES - 1);
   localparam logic [15:0] ERASE_END = 16'(ERASE_CYCLES - 1);
   localparam logic [15:0] SWEEP_END = 16'(ROW_BYTES);
   localparam logic [3:0] RST_CNT_TOP = 4'(RST_MIN_CYC);
   localparam logic [11:0] RECOVER_TOP = 12'(RECOVER_CYC);

   frs_pins_type sync1_q;
   frs_pins_type sync2_q;
   logic sclk_prev_q;
   logic cs_prev_q;
   logic cs_fall, cs_rise, sclk_rise, sclk_fall;
   logic shared_ok, rst_pin_low, hw_fire, blocked;
   logic [3:0] hw_lo_cnt_q;
   logic [11:0] recover_cnt_q;
   logic frame_ok_q;
   logic [2:0] bit_cnt_q;
   logic [2:0] byte_cnt_q;
   logic [7:0] sh_q, next_sh;
   logic [2:0] step;
   logic byte_done;
   logic [7:0] opcode_q, addr_hi_q, addr_mid_q;
   logic [7:0] off_q;
   logic frame_end, whole, busy, row_ok, abort, sw_fire;
   logic [1:0] row_sel;
   logic arm_q;
   frs_state_type state_q;
   logic [15:0] cnt_q;
   logic [1:0] op_row_q;
   logic prog_pend_q;
   logic push_valid;
   frs_word_type push_word, drain_word;
   logic drain_valid, drain_ready;
   logic [7:0] page_q [0:ROW_BYTES-1];
   logic [ROW_BYTES-1:0] mask_q;
   logic [7:0] mem_q [0:ROW_COUNT*ROW_BYTES-1];
   logic [7:0] sweep_idx;
   logic sweeping;
   logic rd_active_q;
   logic [2:0] out_cnt_q;
   logic [7:0] status_now;

   // Only the second stage is looked at by any logic
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync1_q <= PINS_IDLE;
         sync2_q <= PINS_IDLE;
         sclk_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         sync1_q <= link_in;
         sync2_q <= sync1_q;
         sclk_prev_q <= sync2_q.sclk;
         cs_prev_q <= sync2_q.cs_n;
      end
   end

   assign cs_fall = cs_prev_q && !sync2_q.cs_n;
   assign cs_rise = !cs_prev_q && sync2_q.cs_n;
   assign sclk_rise = !sclk_prev_q && sync2_q.sclk && !sync2_q.cs_n;
   assign sclk_fall = sclk_prev_q && !sync2_q.sclk && !sync2_q.cs_n;

   // Hardware reset pin qualification
   assign shared_ok = hold_reset_select_bit && !quad_command_mode_q &&
                      !quad_enable_bit; // [R4]
   assign rst_pin_low = (!dedicated_reset_disable && !sync2_q.reset_n) ||
                        (shared_ok && !sync2_q.hold_reset_n); // [R5]
   assign hw_fire = rst_pin_low && (hw_lo_cnt_q == RST_CNT_TOP - 1'b1);

   always_ff @(posedge core_clk) begin
      if (rst || !rst_pin_low) begin
         hw_lo_cnt_q <= '0;
      end else if (hw_lo_cnt_q != RST_CNT_TOP) begin
         hw_lo_cnt_q <= hw_lo_cnt_q + 1'b1; // [R6]
      end
   end

   // Recovery wait restarts while a valid pulse is still held low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         recover_cnt_q <= '0;
      end else if (hw_fire || hw_lo_cnt_q == RST_CNT_TOP) begin
         recover_cnt_q <= RECOVER_TOP; // [R8]
      end else if (recover_cnt_q != '0) begin
         recover_cnt_q <= recover_cnt_q - 1'b1;
      end
   end

   // A short pulse still blocks input while low, but resets nothing
   assign blocked = rst_pin_low || (recover_cnt_q != '0); // [R7] [R8]
   assign hw_reset_active = blocked;

   // Serial shift-in, one or four lines per clock edge
   assign step = quad_command_mode_q ? 3'h4 : 3'h1;
   assign byte_done = (3'(bit_cnt_q + step) == 3'h0);

   always_comb begin
      if (quad_command_mode_q) begin
         next_sh = {sh_q[3:0], sync2_q.io};
      end else begin
         next_sh = {sh_q[6:0], sync2_q.io[0]};
      end
   end

   // A frame that starts during the block window stays ignored
   always_ff @(posedge core_clk) begin
      if (rst || blocked) begin
         frame_ok_q <= 1'b0;
      end else if (cs_fall) begin
         frame_ok_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || cs_fall) begin
         bit_cnt_q <= '0;
         byte_cnt_q <= '0;
         sh_q <= '0;
         opcode_q <= '0;
         addr_hi_q <= '0;
         addr_mid_q <= '0;
         off_q <= '0;
      end else if (sclk_rise && frame_ok_q) begin
         sh_q <= next_sh;
         bit_cnt_q <= 3'(bit_cnt_q + step);
         if (byte_done) begin
            if (byte_cnt_q != BYTE_CNT_MAX) begin
               byte_cnt_q <= byte_cnt_q + 1'b1;
            end
            case (byte_cnt_q)
               3'h0: opcode_q <= next_sh;
               3'h1: addr_hi_q <= next_sh;
               3'h2: addr_mid_q <= next_sh;
               3'h3: off_q <= next_sh;
               default: off_q <= off_q + 1'b1; // [R20]
            endcase
         end
      end
   end

   assign busy = (state_q != FRS_IDLE) || prog_pend_q || ext_busy;
   assign write_in_progress_flag = busy; // [R19]
   assign frame_end = cs_rise && frame_ok_q;
   assign whole = (bit_cnt_q == 3'h0) && (byte_cnt_q != 3'h0);
   assign row_ok = (addr_hi_q == ROW_UPPER_BYTE) && (addr_mid_q[3:0] == 4'h0)
                   && (addr_mid_q[7:6] == 2'h0); // [R11]
   assign row_sel = addr_mid_q[ROW_SEL_LSB +: 2];
   assign sw_fire = frame_end && whole && (opcode_q == OP_RESET_EXEC) &&
                    arm_q; // [R1]
   assign abort = hw_fire || sw_fire; // [R9]

   // Any complete command other than the arm itself disarms
   always_ff @(posedge core_clk) begin
      if (rst || hw_fire) begin
         arm_q <= 1'b0;
      end else if (frame_end && whole) begin
         arm_q <= (opcode_q == OP_RESET_ARM); // [R2]
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sw_reset_pulse_q <= 1'b0;
      end else begin
         sw_reset_pulse_q <= sw_fire;
      end
   end

   // Mode and volatile parameters; status and function bits are untouched
   always_ff @(posedge core_clk) begin
      if (rst || abort) begin
         quad_command_mode_q <= 1'b0; // [R3] [R10]
         read_params_q <= nv_read_params; // [R3] [R7]
      end else if (quad_mode_enter) begin
         quad_command_mode_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || hw_fire) begin
         deep_power_down_q <= 1'b0; // [R7]
      end else if (dpd_enter) begin
         deep_power_down_q <= 1'b1;
      end
   end

   // Program data path into the FIFO; busy frames push nothing
   assign push_valid = sclk_rise && frame_ok_q && byte_done && !busy &&
                       (byte_cnt_q >= 3'h4) && (opcode_q == OP_ROW_PROGRAM);
   assign push_word = '{offset: off_q, data: next_sh}; // [R20]

   always_ff @(posedge core_clk) begin
      if (rst || cs_fall) begin
         rx_overrun_q <= 1'b0;
      end else if (push_valid && !rx_fifo_ready) begin
         rx_overrun_q <= 1'b1;
      end
   end

   frs_fifo #(
      .WIDTH($bits(frs_word_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(rx_fifo_ready),
      .in_data(push_word),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_word)
   );

   // The page buffer is not touched while a sweep reads it
   assign drain_ready = (state_q != FRS_PROG);

   // Later bytes to the same offset overwrite earlier ones
   always_ff @(posedge core_clk) begin
      if (drain_valid && drain_ready) begin
         page_q[drain_word.offset] <= drain_word.data; // [R20]
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst || (cs_fall && !busy)) begin
         mask_q <= '0;
      end else if (drain_valid && drain_ready) begin
         mask_q[drain_word.offset] <= 1'b1; // [R21]
      end
   end

   // Operation engine and write latch
   always_ff @(posedge core_clk) begin
      if (rst || abort) begin
         state_q <= FRS_IDLE; // [R9]
         cnt_q <= '0;
         prog_pend_q <= 1'b0;
         if (rst) begin
            write_enable_latch_q <= 1'b0;
            op_row_q <= '0;
         end
      end else begin
         case (state_q)
            FRS_IDLE: begin
               cnt_q <= '0;
               if (prog_pend_q && !drain_valid) begin
                  prog_pend_q <= 1'b0;
                  state_q <= FRS_PROG;
               end else if (frame_end && whole && !busy) begin // [R12]
                  if (opcode_q == OP_WRITE_LATCH_SET) begin
                     write_enable_latch_q <= 1'b1;
                  end else if (opcode_q == OP_ROW_ERASE &&
                               byte_cnt_q == ERASE_FRAME_BYTES && row_ok &&
                               write_enable_latch_q && // [R14]
                               !security_row_lock_bit[row_sel]) begin
                     op_row_q <= row_sel; // [R13]
                     state_q <= FRS_ERASE; // [R15]
                  end else if (opcode_q == OP_ROW_PROGRAM &&
                               byte_cnt_q >= PROG_MIN_BYTES && row_ok &&
                               write_enable_latch_q && !rx_overrun_q &&
                               !security_row_lock_bit[row_sel]) begin
                     op_row_q <= row_sel; // [R13] [R17]
                     prog_pend_q <= 1'b1; // [R18]
                  end
               end
            end
            FRS_PROG: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == PROG_END) begin
                  state_q <= FRS_IDLE; // [R19]
                  write_enable_latch_q <= 1'b0;
               end
            end
            FRS_ERASE: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == ERASE_END) begin
                  state_q <= FRS_IDLE;
                  write_enable_latch_q <= 1'b0; // [R16]
               end
            end
            default: state_q <= FRS_IDLE;
         endcase
      end
   end

   // Array sweep over the first ROW_BYTES cycles of an operation
   assign sweeping = (state_q != FRS_IDLE) && (cnt_q < SWEEP_END);
   assign sweep_idx = cnt_q[7:0];

   always_ff @(posedge core_clk) begin
      if (sweeping && state_q == FRS_ERASE) begin
         mem_q[{op_row_q, sweep_idx}] <= 8'hff; // [R22]
      end else if (sweeping && mask_q[sweep_idx]) begin
         mem_q[{op_row_q, sweep_idx}] <=
            mem_q[{op_row_q, sweep_idx}] & page_q[sweep_idx]; // [R22]
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= mem_q[rd_index];
      end
   end

   // Status read answer, sampled live on every output edge
   always_comb begin
      status_now = 8'h00;
      status_now[ST_WIP_BIT] = write_in_progress_flag;
      status_now[ST_WEL_BIT] = write_enable_latch_q;
      status_now[ST_QE_BIT] = quad_enable_bit;
   end

   always_ff @(posedge core_clk) begin
      if (rst || cs_fall || !frame_ok_q) begin
         rd_active_q <= 1'b0;
      end else if (sclk_rise && byte_done && byte_cnt_q == 3'h0 &&
                   next_sh == OP_STATUS_READ) begin
         rd_active_q <= 1'b1; // [R19]
      end
   end

   // Pins float whenever blocked or deselected
   always_ff @(posedge core_clk) begin
      if (rst || blocked || sync2_q.cs_n || !rd_active_q) begin
         io_oe_q <= 4'h0; // [R7]
         io_out_q <= 4'h0;
         out_cnt_q <= '0;
      end else if (sclk_fall) begin
         out_cnt_q <= 3'(out_cnt_q + step);
         if (quad_command_mode_q) begin
            io_oe_q <= 4'hf;
            io_out_q <= out_cnt_q[2] ? status_now[3:0] : status_now[7:4];
         end else begin
            io_oe_q <= 4'h2;
            io_out_q <= {2'h0, status_now[3'h7 - out_cnt_q], 1'h0};
         end
      end
   end

   chk_arm_pair: assert property ( // [R1]
      @(posedge core_clk) disable iff (rst)
      sw_reset_pulse_q |-> $past(arm_q))
      else $error("soft reset without arm");
   chk_arm_drop: assert property ( // [R2]
      @(posedge core_clk) disable iff (rst)
      frame_end && whole && opcode_q != OP_RESET_ARM |=> !arm_q)
      else $error("arm survived other command");
   chk_soft_reload: assert property ( // [R3]
      @(posedge core_clk) disable iff (rst)
      sw_fire |=> read_params_q == $past(nv_read_params) &&
      !quad_command_mode_q && state_q == FRS_IDLE)
      else $error("soft reset did not reload");
   chk_pulse_width: assert property ( // [R6]
      @(posedge core_clk) disable iff (rst)
      hw_fire |-> $past(rst_pin_low, 9) && $past(rst_pin_low, 5))
      else $error("pin reset fired on short pulse");
   // A short pulse never starts the window, so only valid pulses are held
   chk_recover_len: assert property ( // [R8]
      @(posedge core_clk) disable iff (rst)
      !rst_pin_low && hw_lo_cnt_q == RST_CNT_TOP |->
      recover_cnt_q == RECOVER_TOP)
      else $error("recovery window too short");
   chk_float_blocked: assert property ( // [R7]
      @(posedge core_clk) disable iff (rst)
      blocked |=> io_oe_q == 4'h0)
      else $error("pins driven while blocked");
   chk_row_lock: assert property ( // [R13]
      @(posedge core_clk) disable iff (rst)
      $rose(state_q != FRS_IDLE) |-> !security_row_lock_bit[op_row_q])
      else $error("locked row altered");
   chk_busy_reject: assert property ( // [R12]
      @(posedge core_clk) disable iff (rst)
      ext_busy && state_q == FRS_IDLE && !prog_pend_q |=>
      state_q == FRS_IDLE && !prog_pend_q)
      else $error("row command taken while busy");
   chk_erase_latch: assert property ( // [R16]
      @(posedge core_clk) disable iff (rst)
      state_q == FRS_ERASE && cnt_q == ERASE_END && !abort |=>
      !write_enable_latch_q && state_q == FRS_IDLE)
      else $error("latch not cleared after erase");
   chk_progress_flag: assert property ( // [R19]
      @(posedge core_clk) disable iff (rst)
      rd_active_q && sclk_fall && !blocked && !quad_command_mode_q &&
      out_cnt_q == 3'h7 |=> io_out_q[1] == $past(write_in_progress_flag))
      else $error("status answer lost progress flag");

endmodule

// [frs_core_tb_top.sv]
// Self-checking bench for the reset and security row command block
`timescale 1ns/1ps
module frs_core_tb_top;
   import frs_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   frs_pins_type link_in;
   logic [3:0] io_out_q, io_oe_q, security_row_lock_bit = 4'h0;
   logic quad_enable_bit = 1'b0, hold_reset_select_bit = 1'b0;
   logic dedicated_reset_disable = 1'b0, ext_busy = 1'b0;
   logic quad_mode_enter = 1'b0, dpd_enter = 1'b0;
   logic [7:0] nv_read_params = 8'h5c, read_params_q, rd_data_q, rx, prm;
   logic [9:0] rd_index = 10'h000;
   logic write_enable_latch_q, write_in_progress_flag, quad_command_mode_q;
   logic deep_power_down_q, sw_reset_pulse_q, hw_reset_active;
   logic rx_fifo_ready, rx_overrun_q;
   logic [6:0] hc;
   logic [6:0] hw_case[7] = '{7'h0b, 7'h00, 7'h7a, 7'h76, 7'h03, 7'h73,
      7'h22};
   logic [7:0] q[$];
   int fail_count = 0, compares = 0, sw_pulses = 0;
   frs_core #(.PROG_CYCLES(300), .ERASE_CYCLES(300)) dut (
      .core_clk, .rst, .link_in, .io_out_q, .io_oe_q, .quad_enable_bit,
      .hold_reset_select_bit, .dedicated_reset_disable,
      .security_row_lock_bit, .nv_read_params, .ext_busy,
      .quad_mode_enter, .dpd_enter, .write_enable_latch_q,
      .write_in_progress_flag, .quad_command_mode_q, .deep_power_down_q,
      .read_params_q, .sw_reset_pulse_q, .hw_reset_active, .rx_fifo_ready,
      .rx_overrun_q, .rd_index, .rd_data_q);
   frs_host_model host (.core_clk, .io_out_q, .io_oe_q, .link_in);
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (sw_reset_pulse_q === 1'b1) sw_pulses++;
   end
   task automatic print_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input string nm, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmd(input logic [7:0] b[$]);
      host.frame(b, rx);
   endtask
   task automatic rd(input logic [9:0] idx, input logic [7:0] e);
      rd_index = idx;
      tick(2);
      check("row byte", e, rd_data_q);
   endtask
   task automatic latch(input logic e);
      check("latch", {7'h0, e}, {7'h0, write_enable_latch_q});
   endtask
   // Sel 0 watches the progress flag, sel 1 the recovery window
   task automatic wait_for(input int sel, input logic v, input int bound);
      int n;
      n = 0;
      while ((sel ? hw_reset_active : write_in_progress_flag) !== v) begin
         if (n == bound) begin
            fail_count++;
            $display("mismatch wait %0d expected %b", sel, v);
            print_verdict();
         end
         tick(1);
         n++;
      end
      compares++;
   endtask
   initial begin
      tick(8);
      rst = 1'b0;
      tick(6);
      check("params", 8'h5c, read_params_q);
      latch(1'b0);
      cmd('{8'h06});
      latch(1'b1);
      ext_busy = 1'b1;
      cmd('{8'h64, 8'h00, 8'h10, 8'h00});
      ext_busy = 1'b0;
      tick(3);
      check("wip", 8'h00, {7'h0, write_in_progress_flag});
      latch(1'b1);
      cmd('{8'h64, 8'h00, 8'h10, 8'h00});
      wait_for(0, 1'b1, 20);
      wait_for(0, 1'b0, 400);
      latch(1'b0);
      for (int i = 0; i < ROW_BYTES; i++) rd({2'h1, i[7:0]}, 8'hff);
      cmd('{8'h62, 8'h00, 8'h10, 8'h05, 8'haa});
      tick(10);
      check("wip", 8'h00, {7'h0, write_in_progress_flag});
      rd(10'h105, 8'hff);
      cmd('{8'h06});
      cmd('{8'h62, 8'h00, 8'h10, 8'hfe, 8'ha0, 8'ha1, 8'ha2, 8'ha3});
      cmd('{8'h05, 8'h00});
      check("status", 8'h03, rx);
      wait_for(0, 1'b0, 400);
      latch(1'b0);
      rd(10'h1fe, 8'ha0);
      rd(10'h1ff, 8'ha1);
      rd(10'h100, 8'ha2);
      rd(10'h101, 8'ha3);
      rd(10'h102, 8'hff);
      cmd('{8'h06});
      cmd('{8'h62, 8'h00, 8'h10, 8'hfe, 8'h0f});
      wait_for(0, 1'b1, 50);
      wait_for(0, 1'b0, 400);
      rd(10'h1fe, 8'h00);
      cmd('{8'h06});
      cmd('{8'h64, 8'h00, 8'h20, 8'h00});
      wait_for(0, 1'b1, 20);
      wait_for(0, 1'b0, 400);
      cmd('{8'h06});
      q = '{8'h62, 8'h00, 8'h20, 8'h00};
      // First byte at offset 0 is overwritten by the 257th
      for (int i = 0; i <= 256; i++) q.push_back(i == 0 ? 8'h00 : 8'h5a);
      host.frame(q, rx);
      wait_for(0, 1'b1, 50);
      wait_for(0, 1'b0, 400);
      rd(10'h200, 8'h5a);
      check("fifo", 8'h01, {6'h0, rx_overrun_q, rx_fifo_ready});
      for (int k = 0; k < 2; k++) begin
         security_row_lock_bit = k ? 4'h0 : 4'h8;
         cmd('{8'h06});
         cmd('{8'h64, 8'h00, k ? 8'h40 : 8'h30, 8'h00});
         tick(10);
         check("wip", 8'h00, {7'h0, write_in_progress_flag});
      end
      cmd('{8'h64, 8'h00, 8'h30, 8'h00});
      wait_for(0, 1'b1, 20);
      nv_read_params = 8'ha7;
      prm = 8'ha7;
      cmd('{8'h66});
      cmd('{8'h99});
      wait_for(0, 1'b0, 10);
      check("soft resets", 8'h01, sw_pulses[7:0]);
      check("params", 8'ha7, read_params_q);
      cmd('{8'h66});
      cmd('{8'h00});
      cmd('{8'h99});
      check("soft resets", 8'h01, sw_pulses[7:0]);
      for (int c = 0; c < 7; c++) begin
         hc = hw_case[c];
         dedicated_reset_disable = hc[5];
         hold_reset_select_bit = hc[4];
         quad_enable_bit = hc[3];
         nv_read_params = 8'h30 + c[7:0];
         quad_mode_enter = hc[2];
         dpd_enter = 1'b1;
         tick(1);
         quad_mode_enter = 1'b0;
         dpd_enter = 1'b0;
         host.pulse(hc[6], hc[1] ? 12 : 5);
         if (hc[0]) prm = nv_read_params;
         check("dpd", {7'h0, ~hc[0]}, {7'h0, deep_power_down_q});
         check("params", prm, read_params_q);
         check("quad", 8'(hc[2] & ~hc[0]), 8'(quad_command_mode_q));
         if (c == 0) begin
            cmd('{8'h64, 8'h00, 8'h10, 8'h00});
            check("wip", 8'h00, {7'h0, write_in_progress_flag});
         end
         wait_for(1, 1'b0, 4000);
      end
      quad_enable_bit = 1'b0;
      cmd('{8'h64, 8'h00, 8'h10, 8'h00});
      wait_for(0, 1'b1, 20);
      wait_for(0, 1'b0, 400);
      print_verdict();
   end
endmodule

// [frs_fifo.sv]
// Small flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module frs_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   // DEPTH must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_q [0:DEPTH-1];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = cnt_q != FULL_CNT;
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

// [frs_host_model.sv]
// Host controller model that drives the link pins of the command block
`timescale 1ns/1ps
module frs_host_model (
   // Pacing clock
   input wire logic core_clk,
   // Device answer pins
   input wire logic [3:0] io_out_q,
   input wire logic [3:0] io_oe_q,
   // Link pins towards the device
   output frs_pkg::frs_pins_type link_in
);
   import frs_pkg::*;
   frs_pins_type pins = PINS_IDLE;
   logic miso_last = 1'b0;
   // A released answer line flips, so a stale bit never reads as valid
   wire miso = io_oe_q[1] ? io_out_q[1] : ~miso_last;
   always @(posedge core_clk) begin
      if (io_oe_q[1] === 1'b1) miso_last <= io_out_q[1];
   end
   always_comb begin
      link_in = pins;
      link_in.io[1] = miso;
      link_in.io[3:2] = 2'h3;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Clock stands low between frames; each phase lasts 40 ns
   task automatic frame(input logic [7:0] b[$], output logic [7:0] rx);
      pins.cs_n = 1'b0;
      tick(4);
      foreach (b[k]) begin
         for (int i = 7; i >= 0; i--) begin
            pins.io[0] = b[k][i];
            tick(4);
            pins.sclk = 1'b1;
            rx[i] = miso;
            tick(4);
            pins.sclk = 1'b0;
         end
      end
      tick(4);
      pins.cs_n = 1'b1;
      tick(8);
   endtask
   task automatic pulse(input logic shared, input int n);
      if (shared) pins.hold_reset_n = 1'b0;
      else pins.reset_n = 1'b0;
      tick(n);
      pins.hold_reset_n = 1'b1;
      pins.reset_n = 1'b1;
      tick(4);
   endtask
endmodule

// [frs_pkg.sv]
// Shared constants and types for the reset and security row command block
package frs_pkg;

   // Command opcodes
   localparam logic [7:0] OP_RESET_ARM = 8'h66;
   localparam logic [7:0] OP_RESET_EXEC = 8'h99;
   localparam logic [7:0] OP_ROW_ERASE = 8'h64;
   localparam logic [7:0] OP_ROW_PROGRAM = 8'h62;
   localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;

   // Security row address map
   localparam logic [7:0] ROW_UPPER_BYTE = 8'h00;
   localparam int ROW_SEL_LSB = 4;
   localparam int ROW_COUNT = 4;
   localparam int ROW_BYTES = 256;

   // Frame byte counts
   localparam logic [2:0] ERASE_FRAME_BYTES = 3'h4;
   localparam logic [2:0] PROG_MIN_BYTES = 3'h5;
   localparam logic [2:0] BYTE_CNT_MAX = 3'h7;

   // Status byte field positions
   localparam int ST_WIP_BIT = 0;
   localparam int ST_WEL_BIT = 1;
   localparam int ST_QE_BIT = 6;

   // Timing
   localparam int CLK_MHZ = 100;
   localparam int RST_MIN_NS = 100;
   localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVER_US = 35;
   localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
   localparam int PROG_CYC_DEFAULT = 1000;
   localparam int ERASE_CYC_DEFAULT = 2000;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [1:0] {
      FRS_IDLE,
      FRS_PROG,
      FRS_ERASE
   } frs_state_type;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic reset_n;
      logic hold_reset_n;
      logic [3:0] io;
   } frs_pins_type;

   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] data;
   } frs_word_type;

   localparam frs_pins_type PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0,
      reset_n: 1'b1, hold_reset_n: 1'b1, io: 4'h0};

endpackage
